// file: verilog/btfb_pkg.sv
// Package for the bit toggle and flag branch execution block
package btfb_pkg;
	localparam logic [3:0]  BIT_TOGGLE_NIBBLE   = 4'h7;
	localparam logic [7:0]  BRANCH_OVF_BYTE     = 8'hE4;
	localparam logic [7:0]  BRANCH_ZERO_BYTE    = 8'hE0;
	localparam logic [7:0]  ILO_LIMIT           = 8'h5F;
	localparam logic [3:0]  ACCESS_LOW_BANK     = 4'h0;
	localparam logic [3:0]  ACCESS_HIGH_BANK    = 4'hF;
	localparam logic [7:0]  ACCESS_SPLIT        = 8'h60;
	localparam logic [3:0]  BANK_SEL_RESET      = 4'h0;
	localparam logic [20:0] PC_RESET            = 21'h000000;
	localparam logic [20:0] PC_STEP             = 21'h000002;
	localparam int          BIT_FIELD_POS       = 9;
	localparam int          ACCESS_FIELD_POS    = 8;

	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} btfb_phase_type;

	typedef struct packed {
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  data;
	} btfb_dmem_type;
endpackage

// file: verilog/btfb_core.sv
// Execution logic for bit toggle and overflow/zero relative branches
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module btfb_core
	import btfb_pkg::*;
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RESETN_I,
	input  wire logic        EXT_SET_EN_I,
	input  wire logic [15:0] INSTR_I,
	input  wire logic [7:0]  FSR2_I,
	input  wire logic        OVERFLOW_I,
	input  wire logic        ZERO_I,
	input  wire logic        BANK_SEL_WR_I,
	input  wire logic [3:0]  BANK_SEL_WDATA_I,
	input  wire logic [7:0]  DMEM_RDATA_I,
	output logic [11:0]      DMEM_ADDR_O,
	output logic             DMEM_RD_O,
	output logic             DMEM_WR_O,
	output logic [7:0]       DMEM_WDATA_O,
	output logic [20:0]      PC_O,
	output logic             FETCH_O,
	output logic             NOP_CYCLE_O,
	output logic [1:0]       PHASE_O,
	output logic [3:0]       BANK_SEL_O
);

	btfb_phase_type phase;
	logic [15:0]    instr;
	logic [7:0]     data_hold;
	logic [7:0]     offset;
	logic           taken;
	logic           flush;
	logic [3:0]     bank_select_reg;
	btfb_dmem_type  dmem;
	logic [20:0]    pc;

	// Target arithmetic: offset is doubled and sign extended to PC width
	function automatic logic [20:0] rel_target(input logic [20:0] base, input logic [7:0] n);
		logic [20:0] disp;
		disp = {{12{n[7]}}, n, 1'b0};
		rel_target = base + disp;
	endfunction

	// Upper-byte opcode match shared by both branch decodes
	function automatic logic match_byte(input logic [15:0] word, input logic [7:0] code);
		match_byte = (word[15:8] == code);
	endfunction

	// Phase decodes
	wire        in_q1                 = (phase == Q1);
	wire        in_q2                 = (phase == Q2);
	wire        in_q3                 = (phase == Q3);
	wire        in_q4                 = (phase == Q4);

	// A squashed word decodes as nothing, so it can touch neither memory nor PC
	wire        is_bit_toggle_op      = (instr[15:12] == BIT_TOGGLE_NIBBLE) && !flush;
	wire        is_branch_on_overflow_op = match_byte(instr, BRANCH_OVF_BYTE) && !flush;
	wire        is_branch_on_zero_op  = match_byte(instr, BRANCH_ZERO_BYTE) && !flush;
	wire [2:0]  bit_sel               = instr[BIT_FIELD_POS +: 3];
	wire        access_fld            = instr[ACCESS_FIELD_POS];
	wire [7:0]  f_addr                = instr[7:0];

	// Address selection
	wire        use_ilo               = EXT_SET_EN_I && !access_fld && (f_addr <= ILO_LIMIT);
	// Index base plus literal wraps inside eight bits, so indexed access stays in bank 0
	wire [7:0]  ilo_addr              = FSR2_I + f_addr;
	// Access bank splits at 60h: below 60h is bank 0, from 60h up the top bank
	wire [3:0]  access_bank           = (f_addr < ACCESS_SPLIT) ? ACCESS_LOW_BANK
	                                                            : ACCESS_HIGH_BANK;
	// Indexed mode stays inside an 8-bit address; upper bits come from the low bank here
	wire [11:0] eff_addr              = use_ilo    ? {ACCESS_LOW_BANK, ilo_addr}
	                                  : access_fld ? {bank_select_reg, f_addr}
	                                  : {access_bank, f_addr};
	wire [7:0]  toggled               = data_hold ^ (8'h01 << bit_sel);
	// Flags are sampled in Q3 so a flag changed by the previous instruction is seen
	// No flag is an output: all three ops leave the status flags as they were
	wire        cond_ok               = (is_branch_on_overflow_op && OVERFLOW_I)
	                                  || (is_branch_on_zero_op && ZERO_I);
	wire [20:0] pc_inc                = pc + PC_STEP;
	// PC arithmetic wraps at 21 bits
	wire [20:0] next_pc               = taken ? rel_target(pc_inc, offset) : pc_inc;
	// A squashed cycle is never taken itself, so the no-op lasts exactly one cycle
	wire        next_flush            = taken && !flush;
	wire        next_dmem_rd          = in_q1 && is_bit_toggle_op;
	wire        next_dmem_wr          = in_q3 && is_bit_toggle_op;

	// Four clocks per instruction cycle; PHASE_O shows Q1 to Q4 as 0 to 3
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			phase <= Q1;
		else
		begin
			case (phase)
				Q1:      phase <= Q2;
				Q2:      phase <= Q3;
				Q3:      phase <= Q4;
				Q4:      phase <= Q1;
				default: phase <= Q1;
			endcase
		end
	end

	// Instruction latched at the end of Q4 so decode in Q1 sees a stable word
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			instr <= 16'h0000;
		else if (phase == Q4)
			instr <= INSTR_I;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			bank_select_reg <= BANK_SEL_RESET;
		else if (BANK_SEL_WR_I)
			bank_select_reg <= BANK_SEL_WDATA_I;
	end

	// Bank select is loaded from outside; software must not change it mid-instruction
	// Read in Q2, modify in Q3, write back in Q4
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			data_hold <= 8'h00;
		else if (in_q2 && is_bit_toggle_op)
			data_hold <= DMEM_RDATA_I;
	end

	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			dmem <= '0;
		else
		begin
			dmem.wr <= next_dmem_wr;
			if (next_dmem_rd || next_dmem_wr)
				dmem.addr <= eff_addr;
			if (next_dmem_wr)
				dmem.data <= toggled;
		end
	end

	// Read strobe stands for Q2 only, beside the address captured at the end of Q1
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			DMEM_RD_O <= 1'b0;
		else
			DMEM_RD_O <= next_dmem_rd;
	end

	// Offset literal read in Q2
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			offset <= 8'h00;
		else if (in_q2)
			offset <= instr[7:0];
	end

	// Condition evaluated in Q3 and held through Q4 for the PC load
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			taken <= 1'b0;
		else if (in_q3)
			taken <= cond_ok;
	end

	// PC write only on a taken branch; otherwise the normal increment
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			pc <= PC_RESET;
		else if (in_q4)
			pc <= next_pc;
	end

	// A taken branch squashes the already fetched word: next cycle is a no-op
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			flush <= 1'b0;
		else if (in_q4)
			flush <= next_flush;
	end

	// Fetch strobe stands in Q4, when the next word is taken
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			FETCH_O <= 1'b0;
		else
			FETCH_O <= in_q3;
	end

	// Every port below is a plain copy of a flop
	assign DMEM_ADDR_O  = dmem.addr;
	assign DMEM_WR_O    = dmem.wr;
	assign DMEM_WDATA_O = dmem.data;
	assign PC_O         = pc;
	assign NOP_CYCLE_O  = flush;
	assign PHASE_O      = phase;
	assign BANK_SEL_O   = bank_select_reg;

endmodule

`default_nettype wire

// file: testbench/btfb_core_asserts.sv
// Port-level assertions for the bit toggle and flag branch block
`timescale 1ns/1ps
`default_nettype none
module btfb_core_asserts
(
	input wire logic        CLK_SYS_I,
	input wire logic        RESETN_I,
	input wire logic [7:0]  DMEM_RDATA_I,
	input wire logic [11:0] DMEM_ADDR_O,
	input wire logic        DMEM_RD_O,
	input wire logic        DMEM_WR_O,
	input wire logic [7:0]  DMEM_WDATA_O,
	input wire logic [20:0] PC_O,
	input wire logic        FETCH_O,
	input wire logic        NOP_CYCLE_O,
	input wire logic [1:0]  PHASE_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);
	a_phase_step: assert property ($past(RESETN_I) |-> PHASE_O == $past(PHASE_O) + 2'h1) else $error("phase skipped");
	a_rd_in_q2: assert property (DMEM_RD_O |-> PHASE_O == 2'h1) else $error("read off Q2");
	a_wr_in_q4: assert property (DMEM_WR_O |-> PHASE_O == 2'h3) else $error("write off Q4");
	a_wr_after_rd: assert property (DMEM_WR_O |-> $past(DMEM_RD_O, 2)) else $error("no read");
	a_wr_same_addr: assert property (DMEM_WR_O |-> DMEM_ADDR_O == $past(DMEM_ADDR_O, 2))
		else $error("write address moved");
	a_toggle_one_bit: assert property (DMEM_WR_O |->
		$countones(DMEM_WDATA_O ^ $past(DMEM_RDATA_I, 2)) == 1) else $error("not one bit");
	a_nop_quiet: assert property (NOP_CYCLE_O |-> !DMEM_WR_O && !DMEM_RD_O)
		else $error("access in nop cycle");
	a_nop_length: assert property ($rose(NOP_CYCLE_O) |-> PHASE_O == 2'h0 ##0
		NOP_CYCLE_O [*4] ##1 !NOP_CYCLE_O) else $error("nop cycle length");
	a_pc_only_q4: assert property (PHASE_O != 2'h0 |-> $stable(PC_O)) else $error("pc moved");
	a_fetch_in_q4: assert property (FETCH_O |-> PHASE_O == 2'h3) else $error("fetch off Q4");
	c_toggle: cover property (DMEM_WR_O);
	c_taken: cover property ($rose(NOP_CYCLE_O));
	c_pc_jump: cover property (PHASE_O == 2'h0 && PC_O != $past(PC_O) + 21'h2);
endmodule
bind btfb_core btfb_core_asserts btfb_core_asserts_i (.*);
`default_nettype wire

// file: testbench/btfb_dmem_model.sv
// Data memory file answering the block's read and write pulses
`timescale 1ns/1ps
`default_nettype none
module btfb_dmem_model
(
	input wire logic        CLK_SYS_I,
	input wire logic        DMEM_RD_O,
	input wire logic        DMEM_WR_O,
	input wire logic [11:0] DMEM_ADDR_O,
	input wire logic [7:0]  DMEM_WDATA_O,
	output logic [7:0]      DMEM_RDATA_I
);
	logic [7:0] mem [4096];
	logic [7:0] last = 8'h00;
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
	// Outside a read the bus shows inverted stale data so a late sample is caught
	assign DMEM_RDATA_I = DMEM_RD_O ? mem[DMEM_ADDR_O] : ~last;
	always @(posedge CLK_SYS_I)
	begin
		if (DMEM_RD_O) last <= mem[DMEM_ADDR_O];
		if (DMEM_WR_O) mem[DMEM_ADDR_O] <= DMEM_WDATA_O;
	end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the bit toggle and flag branch block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import btfb_pkg::*;
	logic CLK_SYS_I = 0, RESETN_I = 0, EXT_SET_EN_I = 0, OVERFLOW_I = 0, ZERO_I = 0, BANK_SEL_WR_I = 0;
	logic [15:0] INSTR_I = 16'h0000;
	logic [7:0]  FSR2_I = 8'h00, DMEM_RDATA_I, DMEM_WDATA_O;
	logic [3:0]  BANK_SEL_WDATA_I = 4'h0, BANK_SEL_O, bank_sel = 4'h0;
	logic [11:0] DMEM_ADDR_O;
	logic        DMEM_RD_O, DMEM_WR_O, FETCH_O, NOP_CYCLE_O;
	logic [20:0] PC_O;
	logic [1:0]  PHASE_O;
	int          err_total = 0, comparisons = 0, cyc = 0, r;
	integer      seed = 51641;
	btfb_core btfb_core_i (.*);
	btfb_dmem_model btfb_dmem_model_i (.*);
	always #10 CLK_SYS_I = ~CLK_SYS_I;
	task report_and_stop;
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	always @(posedge CLK_SYS_I) if (++cyc == 5000) begin err_total++; report_and_stop; end
	task automatic chk(string what, logic [20:0] exp, logic [20:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask
	function automatic logic [11:0] exp_addr(logic [15:0] i);
		if (i[8]) return {bank_sel, i[7:0]};
		if (EXT_SET_EN_I && i[7:0] <= 8'h5F) return {4'h0, FSR2_I + i[7:0]};
		return {(i[7:0] < 8'h60) ? 4'h0 : 4'hF, i[7:0]};
	endfunction
	// A taken branch is followed by a toggle that the nop cycle must swallow
	task automatic step(logic [15:0] ins, logic v, logic z, logic [15:0] nxt);
		logic [20:0] pc0;
		logic [11:0] a;
		logic [7:0]  old;
		logic        tk;
		a = exp_addr(ins);
		old = btfb_dmem_model_i.mem[a];
		tk = (ins[15:8] == 8'hE4 && v) || (ins[15:8] == 8'hE0 && z);
		do @(posedge CLK_SYS_I); while (PHASE_O !== 2'h2);
		INSTR_I <= ins;
		OVERFLOW_I <= v;
		ZERO_I <= z;
		repeat (2) @(posedge CLK_SYS_I);
		pc0 = PC_O;
		INSTR_I <= tk ? nxt : 16'h0000;
		repeat (4) @(posedge CLK_SYS_I);
		chk("pc", tk ? pc0 + 21'h2 + {{12{ins[7]}}, ins[7:0], 1'b0} : pc0 + 21'h2, PC_O);
		chk("nop", tk, NOP_CYCLE_O);
		if (ins[15:12] == 4'h7) chk("mem", old ^ (8'h01 << ins[11:9]), btfb_dmem_model_i.mem[a]);
		INSTR_I <= 16'h0000;
	endtask
	logic [15:0] corner [6] = '{16'h7E5F, 16'h7060, 16'h715F, 16'hE480, 16'hE07F, 16'hE4FF};
	initial
	begin
		repeat (10) @(posedge CLK_SYS_I);
		RESETN_I <= 1;
		EXT_SET_EN_I <= 1;
		FSR2_I <= 8'hC0;
		@(posedge CLK_SYS_I);
		for (int k = 0; k < 6; k++) step(corner[k], 1, 1, 16'h7A33);
		for (int k = 0; k < 80; k++)
		begin
			r = $random(seed);
			@(posedge CLK_SYS_I);
			BANK_SEL_WR_I <= 1;
			BANK_SEL_WDATA_I <= r[23:20];
			EXT_SET_EN_I <= r[24];
			FSR2_I <= r[31:24];
			@(posedge CLK_SYS_I);
			BANK_SEL_WR_I <= 0;
			bank_sel = r[23:20];
			@(posedge CLK_SYS_I);
			chk("bank_sel", bank_sel, BANK_SEL_O);
			case (r[17:16])
				2'h0: step({4'h7, r[11:0]}, r[18], r[19], 16'h7100);
				2'h1: step({8'hE4, r[7:0]}, r[18], r[19], {4'h7, r[27:16]});
				2'h2: step({8'hE0, r[7:0]}, r[18], r[19], {4'h7, r[27:16]});
				default: step({4'h5, r[11:0]}, r[18], r[19], 16'h0000);
			endcase
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
